// [logic/blt_consts.svh]
// Constants for the backlight configuration register bank.
`ifndef BLT_CONSTS_SVH
`define BLT_CONSTS_SVH

// ***************************************************************
// Bus address and register offsets
// ***************************************************************
`define BLT_DEV_ADDR      7'h38
`define BLT_OFS_CFG_A     8'h00
`define BLT_OFS_CFG_B     8'h01
`define BLT_OFS_PROT      8'h02
`define BLT_OFS_ID        8'h03

// ***************************************************************
// Reset values and field positions
// ***************************************************************
`define BLT_RST_CFG_A     8'h86
`define BLT_RST_CFG_B     8'h28
`define BLT_RST_PROT      2'h0
`define BLT_PROT_HI       7
`define BLT_PROT_LO       6
`define BLT_FAULT_HI      5
`define BLT_NUM_FAULTS    6
`define BLT_NUM_CH        6
// Identity value is arbitrary.
`define BLT_ID_VALUE      8'h5a

`endif

// [logic/blt_pkg.sv]
// Types shared by the backlight configuration register bank.
package blt_pkg;

   // ***************************************************************
   // Modes, states and carriers
   // ***************************************************************
   typedef enum logic [1:0] {
      BLT_DIM_MIX    = 2'h0,
      BLT_DIM_PWM    = 2'h1,
      BLT_DIM_ANALOG = 2'h2,
      BLT_DIM_RSVD   = 2'h3
   } blt_dim_mode_t;

   typedef enum {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
   } blt_state_t;

   typedef struct packed {
      logic          hot_current_reduce_en;
      blt_dim_mode_t dim_mode;
      logic          mix_transfer_point;
      logic          mix_output_set_pin_a;
      logic [1:0]    spread_mod_set_pin_a;
      logic          spread_jitter_range;
      logic          phase_shift_en;
      logic [1:0]    short_threshold_sel;
      logic [1:0]    switch_set_pin_a_sel;
      logic [2:0]    active_channel_sel;
      logic          all_short_protect_en;
      logic          comp_saturation_time_sel;
   } blt_cfg_t;

   typedef struct packed {
      logic fault_pin_to_ground;
      logic fault_overtemp;
      logic fault_output_undervolt;
      logic fault_overcurrent;
      logic fault_string_short;
      logic fault_string_open;
   } blt_fault_t;

endpackage

// [logic/blt_sync.sv]
// Two-stage synchroniser for levels entering a clock domain.
`timescale 1ns/100ps
module blt_sync #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule // blt_sync

// [logic/blt_regs.sv]
// Serial-bus configuration and status register bank with thermal state.
`timescale 1ns/100ps
`include "blt_consts.svh"

module blt_regs
   import blt_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic                    link_clock,
   input  wire logic                    scl_in,
   input  wire logic                    sda_in,
   output logic                         sda_out,
   output logic                         sda_oe,
   input  wire logic                    die_hot,
   input  wire logic                    die_cool,
   input  wire blt_fault_t              fault_in,
   output blt_cfg_t                     cfg,
   output logic [`BLT_NUM_CH-1:0]       active_channels,
   output logic                         thermal_shutdown
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic                       link_rst_meta;
   logic                       link_nrst;
   logic [1:0]                 bus_low;
   logic                       scl_s;
   logic                       sda_s;
   logic                       scl_d;
   logic                       sda_d;
   logic                       scl_rise;
   logic                       scl_fall;
   logic                       start;
   logic                       stop;
   blt_state_t                 state;
   logic [2:0]                 bit_cnt;
   logic [7:0]                 shift;
   logic                       byte_full;
   logic                       rw;
   logic                       nack;
   logic [7:0]                 ptr;
   logic [7:0]                 tx;
   logic [7:0]                 next_tx;
   logic                       wr_commit;
   logic                       rd_load;
   logic                       fault_clr;
   logic [7:0]                 cfg_a;
   logic [7:0]                 cfg_b;
   logic [1:0]                 prot;
   logic [`BLT_FAULT_HI:0]     faults;
   logic [`BLT_FAULT_HI:0]     fault_src;
   logic [`BLT_FAULT_HI:0]     fault_s;
   blt_cfg_t                   link_cfg;
   logic                       cfg_tgl;
   logic                       tgl_s;
   logic                       tgl_d;
   logic [1:0]                 therm_s;

   // ***************************************************************
   // Decode functions
   // ***************************************************************
   function automatic logic [7:0] reg_read(input logic [7:0] p,
                                           input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic [1:0] pr,
                                           input logic [5:0] f);
      logic [7:0] r;
      r = 8'h00;
      if (p == `BLT_OFS_CFG_A) r = a;
      else if (p == `BLT_OFS_CFG_B) r = b;
      else if (p == `BLT_OFS_PROT) r = {pr, f};
      else if (p == `BLT_OFS_ID) r = `BLT_ID_VALUE;
      return r;
   endfunction

   function automatic logic [5:0] chan_mask(input logic [2:0] sel);
      logic [5:0] m;
      m = 6'h3f;
      unique case (sel)
         3'h0: m = 6'h3f;
         3'h1: m = 6'h1f;
         3'h2: m = 6'h0f;
         3'h3: m = 6'h07;
         3'h4: m = 6'h03;
         3'h5: m = 6'h01;
         default: m = 6'h3f;
      endcase
      return m;
   endfunction

   // ***************************************************************
   // Link reset release and pin sampling
   // ***************************************************************
   // Reset leaves the link domain synchronously so no bus flop sees a
   // release edge that races the sampling clock.
   always_ff @(posedge link_clock or negedge nrst) begin
      if (!nrst) begin
         link_rst_meta <= 1'b0;
         link_nrst     <= 1'b0;
      end else begin
         link_rst_meta <= 1'b1;
         link_nrst     <= link_rst_meta;
      end
   end

   // The pins idle high, so they cross inverted: the cleared
   // synchroniser then reads as an idle bus and no false edge
   // follows reset.
   blt_sync #(.W(2)) u_bus_sync (
      .clock (link_clock),
      .nrst  (link_nrst),
      .d     (~{scl_in, sda_in}),
      .q     (bus_low)
   );

   assign scl_s = ~bus_low[1];
   assign sda_s = ~bus_low[0];

   always_ff @(posedge link_clock or negedge link_nrst) begin
      if (!link_nrst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start    = scl_s & scl_d & sda_d & ~sda_s;
   assign stop     = scl_s & scl_d & ~sda_d & sda_s;

   // ***************************************************************
   // Bus protocol engine
   // ***************************************************************
   assign next_tx   = reg_read(ptr, cfg_a, cfg_b, prot, faults);
   assign wr_commit = (state == ST_WDATA) && byte_full && scl_fall
                      && !start && !stop;
   assign rd_load   = scl_fall && !start && !stop
                      && (((state == ST_ADDR_ACK) && rw)
                          || ((state == ST_RACK) && !nack));
   assign fault_clr = rd_load && (ptr == `BLT_OFS_PROT);

   always_ff @(posedge link_clock or negedge link_nrst) begin
      if (!link_nrst) begin
         state     <= ST_IDLE;
         bit_cnt   <= 3'h0;
         shift     <= 8'h00;
         byte_full <= 1'b0;
         rw        <= 1'b0;
         nack      <= 1'b0;
         ptr       <= 8'h00;
         tx        <= 8'h00;
         sda_oe    <= 1'b0;
         sda_out   <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         if (start) begin
            state     <= ST_ADDR;
            bit_cnt   <= 3'h0;
            byte_full <= 1'b0;
            sda_oe    <= 1'b0;
         end else if (stop) begin
            state     <= ST_IDLE;
            byte_full <= 1'b0;
            sda_oe    <= 1'b0;
         end else if (scl_rise) begin
            if (state == ST_RACK) begin
               nack <= sda_s;
            end else if (state inside {ST_ADDR, ST_PTR, ST_WDATA,
                                       ST_RDATA}) begin
               shift   <= {shift[6:0], sda_s};
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  byte_full <= 1'b1;
               end
            end
         end else if (scl_fall) begin
            unique case (state)
               ST_IDLE: begin
                  sda_oe <= 1'b0;
               end
               ST_ADDR: if (byte_full) begin
                  byte_full <= 1'b0;
                  if (shift[7:1] == `BLT_DEV_ADDR) begin
                     rw     <= shift[0];
                     sda_oe <= 1'b1;
                     state  <= ST_ADDR_ACK;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
               ST_ADDR_ACK: begin
                  if (rw) begin
                     tx     <= next_tx;
                     sda_oe <= ~next_tx[7];
                     ptr    <= ptr + 8'h01;
                     state  <= ST_RDATA;
                  end else begin
                     sda_oe <= 1'b0;
                     state  <= ST_PTR;
                  end
               end
               ST_PTR: if (byte_full) begin
                  byte_full <= 1'b0;
                  ptr       <= shift;
                  sda_oe    <= 1'b1;
                  state     <= ST_PTR_ACK;
               end
               ST_PTR_ACK: begin
                  sda_oe <= 1'b0;
                  state  <= ST_WDATA;
               end
               ST_WDATA: if (byte_full) begin
                  byte_full <= 1'b0;
                  ptr       <= ptr + 8'h01;
                  sda_oe    <= 1'b1;
                  state     <= ST_WDATA_ACK;
               end
               ST_WDATA_ACK: begin
                  sda_oe <= 1'b0;
                  state  <= ST_WDATA;
               end
               ST_RDATA: begin
                  if (byte_full) begin
                     byte_full <= 1'b0;
                     sda_oe    <= 1'b0;
                     state     <= ST_RACK;
                  end else begin
                     tx     <= {tx[6:0], 1'b0};
                     sda_oe <= ~tx[6];
                  end
               end
               ST_RACK: begin
                  if (nack) begin
                     state <= ST_IDLE;
                  end else begin
                     tx     <= next_tx;
                     sda_oe <= ~next_tx[7];
                     ptr    <= ptr + 8'h01;
                     state  <= ST_RDATA;
                  end
               end
            endcase
         end
      end
   end

   // ***************************************************************
   // Register storage
   // ***************************************************************
   always_ff @(posedge link_clock or negedge link_nrst) begin
      if (!link_nrst) begin
         cfg_a   <= `BLT_RST_CFG_A;
         cfg_b   <= `BLT_RST_CFG_B;
         prot    <= `BLT_RST_PROT;
         cfg_tgl <= 1'b0;
      end else if (wr_commit) begin
         cfg_tgl <= ~cfg_tgl;
         if (ptr == `BLT_OFS_CFG_A) begin
            cfg_a <= shift;
         end else if (ptr == `BLT_OFS_CFG_B) begin
            cfg_b <= shift;
         end else if (ptr == `BLT_OFS_PROT) begin
            // Only the two control bits take the byte.
            prot <= shift[`BLT_PROT_HI:`BLT_PROT_LO];
         end
      end
   end

   // A fault still present when its flag is read sets it again at once.
   always_ff @(posedge link_clock or negedge link_nrst) begin
      if (!link_nrst) begin
         faults <= '0;
      end else begin
         faults <= (faults & ~{`BLT_NUM_FAULTS{fault_clr}})
                   | fault_s;
      end
   end

   blt_sync #(.W(`BLT_NUM_FAULTS)) u_fault_sync (
      .clock (link_clock),
      .nrst  (link_nrst),
      .d     (fault_src),
      .q     (fault_s)
   );

   assign link_cfg = blt_cfg_t'({cfg_a, cfg_b, prot});

   // ***************************************************************
   // Core domain: fault sources, configuration copy, thermal state
   // ***************************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fault_src <= '0;
      end else begin
         fault_src <= fault_in | {1'b0, thermal_shutdown, 4'h0};
      end
   end

   blt_sync #(.W(1)) u_tgl_sync (
      .clock (clock),
      .nrst  (nrst),
      .d     (cfg_tgl),
      .q     (tgl_s)
   );

   // The copied word is held still by the link side for a whole byte
   // time after each toggle, so sampling it here is safe.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tgl_d           <= 1'b0;
         cfg             <= blt_cfg_t'({`BLT_RST_CFG_A, `BLT_RST_CFG_B,
                                        `BLT_RST_PROT});
         active_channels <= {`BLT_NUM_CH{1'b1}};
      end else begin
         tgl_d <= tgl_s;
         if (tgl_s != tgl_d) begin
            cfg             <= link_cfg;
            active_channels <=
               chan_mask(link_cfg.active_channel_sel);
         end
      end
   end

   blt_sync #(.W(2)) u_therm_sync (
      .clock (clock),
      .nrst  (nrst),
      .d     ({die_hot, die_cool}),
      .q     (therm_s)
   );

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         thermal_shutdown <= 1'b0;
      end else if (therm_s[1]) begin
         thermal_shutdown <= 1'b1;
      end else if (therm_s[0]) begin
         thermal_shutdown <= 1'b0;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sequence s_addr_done;
      (state == ST_ADDR) && byte_full && scl_fall && !start && !stop;
   endsequence

   sequence s_ptr_done;
      (state == ST_PTR) && byte_full && scl_fall && !start && !stop;
   endsequence

   a_thermal_enter: assert property (
      @(posedge clock) disable iff (!nrst)
      therm_s[1] |=> thermal_shutdown)
      else $error("thermal shutdown not entered");

   a_thermal_hyst: assert property (
      @(posedge clock) disable iff (!nrst)
      thermal_shutdown && !therm_s[0] |=> thermal_shutdown)
      else $error("thermal shutdown left above lower threshold");

   a_addr_reject: assert property (
      @(posedge link_clock) disable iff (!link_nrst)
      s_addr_done ##0 (shift[7:1] != `BLT_DEV_ADDR)
      |=> (state == ST_IDLE) && !sda_oe)
      else $error("foreign address answered");

   a_addr_ack: assert property (
      @(posedge link_clock) disable iff (!link_nrst)
      s_addr_done ##0 (shift[7:1] == `BLT_DEV_ADDR)
      |=> sda_oe && (state == ST_ADDR_ACK) && (rw == $past(shift[0])))
      else $error("own address not acknowledged");

   a_ptr_capture: assert property (
      @(posedge link_clock) disable iff (!link_nrst)
      s_ptr_done |=> (ptr == $past(shift)) && sda_oe)
      else $error("register pointer not captured");

   a_cfg_write: assert property (
      @(posedge link_clock) disable iff (!link_nrst)
      wr_commit && (ptr == `BLT_OFS_CFG_A) |=> cfg_a == $past(shift))
      else $error("control byte write lost");

   a_ro_write: assert property (
      @(posedge link_clock) disable iff (!link_nrst)
      wr_commit && (ptr == `BLT_OFS_PROT) && !fault_clr
      |=> (faults & $past(faults)) == $past(faults)
          && prot == $past(shift[7:6]))
      else $error("write disturbed read-only fault bits");

   a_fault_sticky: assert property (
      @(posedge link_clock) disable iff (!link_nrst)
      !fault_clr |=> (faults & $past(faults)) == $past(faults))
      else $error("fault flag dropped without read");

   a_fault_set: assert property (
      @(posedge link_clock) disable iff (!link_nrst)
      fault_clr |=> faults == $past(fault_s))
      else $error("fault read clear wrong or set lost");

   a_cfg_cross: assert property (
      @(posedge clock) disable iff (!nrst)
      (tgl_s != tgl_d) |=> (cfg == $past(link_cfg))
      && active_channels == chan_mask($past(link_cfg.active_channel_sel)))
      else $error("configuration copy not taken");

endmodule // blt_regs

// [tb/blt_i2c_master.sv]
// Bit-level serial bus master that drives the register bank's pins.
`timescale 1ns/100ps
module blt_i2c_master #(
   parameter int Q = 21
) (
   input  wire logic clock,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // Q cycles of 25 ns keep each scl phase above four link periods.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic wt();
      repeat (Q) @(negedge clock);
   endtask

   // Also serves as a repeated start when scl is low on entry.
   task automatic start();
      wt();
      sda_low = 1'b0;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b1;
      wt();
      scl = 1'b0;
   endtask

   task automatic stop();
      wt();
      sda_low = 1'b1;
      wt();
      scl = 1'b1;
      wt();
      sda_low = 1'b0;
      wt();
      wt();
   endtask

   task automatic bit_io(input logic b, output logic r);
      wt();
      sda_low = !b;
      wt();
      scl = 1'b1;
      wt();
      r = sda;
      wt();
      scl = 1'b0;
   endtask

   task automatic put(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask

   task automatic get(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(last, r);
   endtask
endmodule // blt_i2c_master

// [tb/testbench.sv]
// Self-checking bench for the backlight configuration register bank.
`timescale 1ns/100ps
`include "blt_consts.svh"
`define TB_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   n_mismatch++; $display("Error at %0t: got %h expected %h", \
   $time, (g), (e)); end end
module testbench
   import blt_pkg::*;
;
   logic            clock = 1'b0;
   logic            link_clock = 1'b0;
   logic            nrst;
   logic            die_hot;
   logic            die_cool;
   blt_fault_t      fault_in;
   logic            scl;
   logic            sda_low;
   logic            sda_out;
   logic            sda_oe;
   logic            thermal_shutdown;
   blt_cfg_t        cfg;
   logic [5:0]      active_channels;
   int              n_mismatch = 0;
   int              checks_done = 0;
   int              regs [3];
   int              flt = 0;
   logic [7:0]      rs = 8'h5e;
   // Pull-up on the data wire; either party may pull it low.
   wire             sda = !(sda_low || (sda_oe && !sda_out));

   always #12.5 clock = ~clock;
   initial begin
      #7.3;
      forever #62.5 link_clock = ~link_clock;
   end

   blt_regs u_blt_regs (.clock(clock), .nrst(nrst),
      .link_clock(link_clock), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .die_hot(die_hot),
      .die_cool(die_cool), .fault_in(fault_in), .cfg(cfg),
      .active_channels(active_channels),
      .thermal_shutdown(thermal_shutdown));
   blt_i2c_master u_blt_i2c_master (.clock(clock), .sda(sda),
      .scl(scl), .sda_low(sda_low));

   // ***************************************************************
   // Reference model and bus tasks
   // ***************************************************************
   function automatic logic [7:0] nxt();
      rs = {rs[6:0], rs[7] ^ rs[5] ^ rs[4] ^ rs[3]};
      return rs;
   endfunction

   function automatic logic [7:0] exp_rd(input int p);
      case (p)
         0: return regs[0][7:0];
         1: return regs[1][7:0];
         2: return {regs[2][7:6], flt[5:0]};
         3: return `BLT_ID_VALUE;
         default: return 8'h00;
      endcase
   endfunction

   task automatic sel(input logic rw);
      logic a;
      u_blt_i2c_master.start();
      u_blt_i2c_master.put({7'h38, rw}, a);
      `TB_CHK(a, 1'b1)
   endtask

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$]);
      logic a;
      int   p;
      p = ptr;
      sel(1'b0);
      u_blt_i2c_master.put(ptr, a);
      foreach (d[i]) begin
         u_blt_i2c_master.put(d[i], a);
         if (p < 2) regs[p] = d[i];
         if (p == 2) regs[2] = d[i] & 8'hc0;
         p = (p + 1) % 256;
      end
      u_blt_i2c_master.stop();
   endtask

   task automatic rd(input logic [7:0] ptr, input int n);
      logic       a;
      logic [7:0] v;
      int         p;
      p = ptr;
      sel(1'b0);
      u_blt_i2c_master.put(ptr, a);
      sel(1'b1);
      for (int i = 0; i < n; i++) begin
         u_blt_i2c_master.get(i == n - 1, v);
         `TB_CHK(v, exp_rd(p))
         // A fault still present sets its flag again after the read.
         if (p == 2) flt = fault_in | {1'b0, thermal_shutdown, 4'h0};
         p = (p + 1) % 256;
      end
      u_blt_i2c_master.stop();
   endtask

   task automatic chk_out();
      logic [17:0] e;
      int          c;
      repeat (40) @(negedge clock);
      e = {regs[0][7:0], regs[1][7:0], regs[2][7:6]};
      c = regs[1] & 7;
      `TB_CHK(cfg, e)
      `TB_CHK(active_channels, (c > 5) ? 6'h3f : 6'h3f >> c)
   endtask

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      logic [7:0] r;
      logic [7:0] a0;
      logic [7:0] a1;
      logic       a;
      logic [6:0] bad [2];
      bad = '{7'h0e, 7'h39};
      nrst = 1'b0;
      die_hot = 1'b0;
      die_cool = 1'b0;
      fault_in = '0;
      regs = '{8'h86, 8'h28, 8'h00};
      // Reset is asynchronous, so four cycles reach the link side too.
      repeat (4) @(negedge clock);
      nrst = 1'b1;
      repeat (40) @(negedge clock);
      `TB_CHK(thermal_shutdown, 1'b0)
      `TB_CHK({sda_oe, sda_out}, 2'h0)
      chk_out();
      rd(8'h00, 5);
      $display("Test reset values done");
      for (int k = 0; k < 2; k++) begin
         u_blt_i2c_master.start();
         u_blt_i2c_master.put({bad[k], 1'b0}, a);
         `TB_CHK(a, 1'b0)
         u_blt_i2c_master.put(8'h00, a);
         u_blt_i2c_master.put(8'h00, a);
         u_blt_i2c_master.stop();
      end
      chk_out();
      $display("Test foreign address done");
      // No configuration pin here, so every function follows its bits.
      for (int i = 0; i < 8; i++) begin
         r = nxt();
         a0 = {r[7], i[1:0], r[4:3], i[1:0], r[0]};
         r = nxt();
         a1 = {r[7:3], i[2:0]};
         r = nxt();
         wr(8'h00, '{a0, a1, r, ~r});
         chk_out();
         if (i[0]) rd(8'h00, 4);
      end
      $display("Test register writes done");
      r = nxt();
      fault_in = r[5:0];
      repeat (40) @(negedge clock);
      fault_in = 6'h20;
      flt = r[5:0] | 6'h20;
      repeat (40) @(negedge clock);
      rd(8'h02, 1);
      rd(8'h02, 1);
      fault_in = '0;
      $display("Test fault flags done");
      die_hot = 1'b1;
      repeat (40) @(negedge clock);
      `TB_CHK(thermal_shutdown, 1'b1)
      die_hot = 1'b0;
      repeat (40) @(negedge clock);
      `TB_CHK(thermal_shutdown, 1'b1)
      die_cool = 1'b1;
      repeat (40) @(negedge clock);
      `TB_CHK(thermal_shutdown, 1'b0)
      die_hot = 1'b1;
      repeat (40) @(negedge clock);
      `TB_CHK(thermal_shutdown, 1'b1)
      die_hot = 1'b0;
      flt = flt | 6'h10;
      repeat (40) @(negedge clock);
      `TB_CHK(thermal_shutdown, 1'b0)
      rd(8'h02, 1);
      $display("Test thermal shutdown done");
      stop_test();
   end

   initial begin
      repeat (95000) @(posedge clock);
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule // testbench
